/* File: lin_mode_control.sv */
// LIN mode control: role select, autobaud, shared state machine and master break timing.
// Assumes an AHB-Lite master on clk_in and a LIN transceiver on the pins.
//
// Functional notes
// R01 - LIN control register visible at its address only when mode select is LIN.
// R02 - Master operation needs master bit set, multiproc, parity and slave bits clear.
// R03 - Slave operation needs slave bit set, multiproc, parity and master bits clear.
// R04 - Autobaud acts only when enabled and operating as slave.
// R05 - With autobaud interrupt enabled, completion sets the done flag and interrupts.
// R06 - The autobaud interrupt carries no received byte.
// R07 - Autobaud completion writes the measured bit period into the divisor.
// R08 - Software state writes apply at once and override hardware progression.
// R09 - Slave hardware steps from wait for break through autobaud to active.
// R10 - Software returns a slave to sleep and otherwise leaves the state alone; the code loads any written state code in either role.
// R11 - Master goes sleep to active and stays until software writes sleep; the code leaves active on any written state code other than active.
// R12 - State codes: sleep, wait for break, autobaud.
// R13 - Master break lasts 13 to 16 bit times per the break length field.
// R14 - High and low baud bytes form one 16-bit divisor.
// R15 - State code 11 is active, normal frames in either role.
`timescale 1ns/1ps
`include "lin_regs.svh"
module lin_mode_control
  import lin_pkg::*;
(
  // Clock, reset and enable
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        ce_in,
  // AHB-Lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic [31:0]      hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // LIN line
  input  wire logic        rx_pin_in,
  output logic             tx_break_out,
  // Status
  output logic [1:0]       lin_state_out,
  output logic             irq_out
);

  // --------------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------------
  function automatic reg_sel_type decode(input logic [31:0] addr, input logic lin_mode);
    reg_sel_type sel;
    sel = SEL_NONE;
    if (addr[31:18] != 14'h0000 || addr[1:0] != 2'b00) begin
      sel = SEL_NONE;
    end else if (addr[17:2] == `LIN_MODE_IDX) begin
      sel = SEL_MODE;
    end else if (addr[17:2] == `LIN_CTL_IDX && lin_mode) begin
      sel = SEL_CTL; // R01
    end else if (addr[17:2] == `LIN_BRH_IDX) begin
      sel = SEL_BRH;
    end else if (addr[17:2] == `LIN_BRL_IDX) begin
      sel = SEL_BRL;
    end else if (addr[17:2] == `LIN_STAT_IDX) begin
      sel = SEL_STAT;
    end else if (addr[17:2] == `LIN_MASK_IDX) begin
      sel = SEL_MASK;
    end else if (addr[17:2] == `LIN_CMD_IDX) begin
      sel = SEL_CMD;
    end
    return sel;
  endfunction

  function automatic logic [1:0] state_code(input lin_fsm_type st);
    logic [1:0] c;
    c = `LIN_CODE_SLEEP;
    case (st)
      ST_WAIT:     c = `LIN_CODE_WAIT; // R12
      ST_AUTOBAUD: c = `LIN_CODE_AUTOBAUD; // R12
      ST_ACTIVE:   c = `LIN_CODE_ACTIVE; // R15
      default:     c = `LIN_CODE_SLEEP; // R12
    endcase
    return c;
  endfunction

  function automatic lin_fsm_type code_state(input logic [1:0] c);
    lin_fsm_type st;
    st = ST_SLEEP;
    case (c)
      `LIN_CODE_WAIT:     st = ST_WAIT;
      `LIN_CODE_AUTOBAUD: st = ST_AUTOBAUD;
      `LIN_CODE_ACTIVE:   st = ST_ACTIVE;
      default:            st = ST_SLEEP;
    endcase
    return st;
  endfunction

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  logic [2:0]  mode_sel_r;
  logic        multiproc_enable_r;
  logic        pen_r;
  logic        master_sel_r;
  logic        slave_sel_r;
  logic        ab_en_r;
  logic        ab_irq_en_r;
  logic [1:0]  break_len_r;
  logic [15:0] divisor_r;
  logic [1:0]  stat_r;
  logic [1:0]  stat_nxt;
  logic [1:0]  mask_r;
  lin_fsm_type fsm_r;
  lin_fsm_type fsm_nxt;
  brk_fsm_type brk_r;
  logic        a_wr_r;
  reg_sel_type a_sel_r;
  logic        lin_mode;
  logic        master_op;
  logic        slave_op;
  logic        ab_active;
  logic        addr_ok;
  reg_sel_type addr_sel;
  logic        wr_ctl;
  logic [7:0]  wbyte;
  logic        rx_s;
  logic        rx_d_r;
  logic [19:0] low_cnt_r;
  logic        brk_seen;
  logic        meter_done;
  logic [15:0] meter_period;
  logic        ab_hit;
  logic [20:0] brk_cnt_r;
  logic [20:0] brk_total_r;
  logic        brk_start;
  logic        brk_end;

  assign lin_mode  = (mode_sel_r == `LIN_MODE_LIN);
  assign master_op = master_sel_r & ~multiproc_enable_r & ~pen_r & ~slave_sel_r; // R02
  assign slave_op  = slave_sel_r & ~multiproc_enable_r & ~pen_r & ~master_sel_r; // R03
  assign ab_active = ab_en_r & slave_op; // R04
  assign addr_ok   = hsel_in & htrans_in[1] & hready_in;
  assign addr_sel  = decode(haddr_in, lin_mode);
  assign wr_ctl    = a_wr_r && a_sel_r == SEL_CTL;
  assign wbyte     = hwdata_in[7:0];
  assign ab_hit    = meter_done & ab_active & (fsm_r == ST_AUTOBAUD);

  // --------------------------------------------------------------------------
  // Bus slave
  // --------------------------------------------------------------------------
  // Zero wait states: read data are registered at the address phase edge.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      a_wr_r        <= 1'b0;
      a_sel_r       <= SEL_NONE;
      hrdata_out    <= 32'h0000_0000;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end else if (ce_in) begin
      a_wr_r  <= addr_ok & hwrite_in;
      a_sel_r <= addr_sel;
      if (addr_ok && !hwrite_in) begin
        if (addr_sel == SEL_MODE) begin
          hrdata_out <= {27'h0, pen_r, multiproc_enable_r, mode_sel_r};
        end else if (addr_sel == SEL_CTL) begin
          hrdata_out <= {24'h0, master_sel_r, slave_sel_r, ab_en_r, ab_irq_en_r,
                         state_code(fsm_r), break_len_r};
        end else if (addr_sel == SEL_BRH) begin
          hrdata_out <= {24'h0, divisor_r[15:8]};
        end else if (addr_sel == SEL_BRL) begin
          hrdata_out <= {24'h0, divisor_r[7:0]};
        end else if (addr_sel == SEL_STAT) begin
          hrdata_out <= {30'h0, stat_r};
        end else if (addr_sel == SEL_MASK) begin
          hrdata_out <= {30'h0, mask_r};
        end else begin
          hrdata_out <= 32'h0000_0000;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_sel_r   <= 3'(`LIN_MODE_RST);
      multiproc_enable_r       <= 1'b0;
      pen_r        <= 1'b0;
      master_sel_r <= 1'b0;
      slave_sel_r  <= 1'b0;
      ab_en_r      <= 1'b0;
      ab_irq_en_r  <= 1'b0;
      break_len_r  <= 2'(`LIN_CTL_RST);
      mask_r       <= 2'(`LIN_MASK_RST);
    end else if (ce_in && a_wr_r) begin
      if (a_sel_r == SEL_MODE) begin
        mode_sel_r <= wbyte[`LIN_MODE_SEL_HI:`LIN_MODE_SEL_LO];
        multiproc_enable_r     <= wbyte[`LIN_MULTIPROC_ENABLE_BIT];
        pen_r      <= wbyte[`LIN_PEN_BIT];
      end else if (a_sel_r == SEL_CTL) begin
        master_sel_r <= wbyte[`LIN_CTL_MST_BIT];
        slave_sel_r  <= wbyte[`LIN_CTL_SLV_BIT];
        ab_en_r      <= wbyte[`LIN_CTL_AUTOBAUD_ENABLE_BIT_BIT];
        ab_irq_en_r  <= wbyte[`LIN_CTL_AUTOBAUD_IRQ_ENABLE_BIT];
        break_len_r  <= wbyte[`LIN_CTL_BRK_HI:`LIN_CTL_BRK_LO];
      end else if (a_sel_r == SEL_MASK) begin
        mask_r <= wbyte[1:0];
      end
    end
  end

  // Hardware update wins over a software byte write in the same cycle.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      divisor_r <= {`LIN_BR_RST, `LIN_BR_RST};
    end else if (ce_in) begin
      if (ab_hit) begin
        divisor_r <= meter_period; // R07 R14
      end else if (a_wr_r && a_sel_r == SEL_BRH) begin
        divisor_r[15:8] <= wbyte; // R14
      end else if (a_wr_r && a_sel_r == SEL_BRL) begin
        divisor_r[7:0] <= wbyte; // R14
      end
    end
  end

  // --------------------------------------------------------------------------
  // Receive side
  // --------------------------------------------------------------------------
  lin_sync u_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .ce_in    (ce_in),
    .pin_in   (rx_pin_in),
    .sync_out (rx_s)
  );

  // A break is a low of at least eleven bit times at the current divisor.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_d_r    <= 1'b1;
      low_cnt_r <= 20'h00000;
    end else if (ce_in) begin
      rx_d_r <= rx_s;
      if (rx_s || fsm_r != ST_WAIT) begin
        low_cnt_r <= 20'h00000;
      end else if (low_cnt_r != 20'hfffff) begin
        low_cnt_r <= low_cnt_r + 20'h00001;
      end
    end
  end

  assign brk_seen = rx_s & ~rx_d_r & (low_cnt_r >= {4'h0, divisor_r} * `LIN_BREAK_DETECT);

  lin_autobaud_meter #(
    .CNT_W (19)
  ) u_meter (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n_in),
    .ce_in      (ce_in),
    .arm_in     (fsm_r == ST_AUTOBAUD && slave_op),
    .rx_in      (rx_s),
    .done_out   (meter_done),
    .period_out (meter_period)
  );

  // --------------------------------------------------------------------------
  // Protocol state machine
  // --------------------------------------------------------------------------
  always_comb begin
    fsm_nxt = fsm_r;
    if (wr_ctl) begin
      fsm_nxt = code_state(wbyte[`LIN_CTL_ST_HI:`LIN_CTL_ST_LO]); // R08 R10
    end else begin
      case (fsm_r)
        ST_WAIT: begin
          if (slave_op && brk_seen) begin
            fsm_nxt = ST_AUTOBAUD; // R09
          end
        end
        ST_AUTOBAUD: begin
          if (slave_op && meter_done) begin
            fsm_nxt = ST_ACTIVE; // R09
          end
        end
        ST_ACTIVE: fsm_nxt = ST_ACTIVE; // R11
        default:   fsm_nxt = fsm_r;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fsm_r         <= ST_SLEEP;
      lin_state_out <= `LIN_CODE_SLEEP;
    end else if (ce_in) begin
      fsm_r         <= fsm_nxt;
      lin_state_out <= state_code(fsm_nxt);
    end
  end

  // --------------------------------------------------------------------------
  // Master break
  // --------------------------------------------------------------------------
  assign brk_start = a_wr_r && a_sel_r == SEL_CMD && wbyte[`LIN_CMD_BRK_BIT] &&
                     master_op && fsm_r == ST_ACTIVE && brk_r == BRK_IDLE;
  assign brk_end   = brk_r == BRK_SEND && brk_cnt_r + 21'd1 >= brk_total_r;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      brk_r        <= BRK_IDLE;
      brk_cnt_r    <= 21'h000000;
      brk_total_r  <= 21'h000000;
      tx_break_out <= 1'b1;
    end else if (ce_in) begin
      case (brk_r)
        BRK_IDLE: begin
          brk_cnt_r <= 21'h000000;
          if (brk_start) begin
            brk_r        <= BRK_SEND;
            brk_total_r  <= 21'({3'h0, break_len_r} + `LIN_BREAK_BASE) * 21'(divisor_r); // R13
            tx_break_out <= 1'b0;
          end
        end
        BRK_SEND: begin
          brk_cnt_r <= brk_cnt_r + 21'd1;
          if (brk_end) begin
            brk_r        <= BRK_IDLE; // R13
            tx_break_out <= 1'b1;
          end
        end
        default: brk_r <= BRK_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt status
  // --------------------------------------------------------------------------
  // A set in the cycle of a clearing read survives; no data flag joins it.
  always_comb begin
    stat_nxt = stat_r;
    if (ce_in && addr_ok && !hwrite_in && addr_sel == SEL_STAT) begin
      stat_nxt = 2'b00;
    end
    if (ce_in && ab_hit && ab_irq_en_r) begin
      stat_nxt[`LIN_STAT_ABD_BIT] = 1'b1; // R05 R06
    end
    if (ce_in && brk_end) begin
      stat_nxt[`LIN_STAT_BRK_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stat_r  <= 2'b00;
      irq_out <= 1'b0;
    end else if (ce_in) begin
      stat_r  <= stat_nxt;
      irq_out <= |(stat_nxt & mask_r);
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  logic [20:0] brk_meas_r;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      brk_meas_r <= 21'h000000;
    end else if (ce_in) begin
      brk_meas_r <= tx_break_out ? 21'h000000 : brk_meas_r + 21'd1;
    end
  end

  property p_ctl_hidden;
    @(posedge clk_in) disable iff (!rst_n_in)
    ce_in && addr_ok && !hwrite_in && haddr_in == {14'h0, `LIN_CTL_IDX, 2'b00} && !lin_mode
    |=> hrdata_out == 32'h0000_0000;
  endproperty
  a_ctl_hidden: assert property (p_ctl_hidden) else $error("LIN control read outside LIN mode"); // R01
  property p_master_only;
    @(posedge clk_in) disable iff (!rst_n_in)
    $fell(tx_break_out) |-> $past(master_op) && $past(fsm_r) == ST_ACTIVE;
  endproperty
  a_master_only: assert property (p_master_only) else $error("Break sent outside master"); // R02
  property p_slave_hold;
    @(posedge clk_in) disable iff (!rst_n_in)
    ce_in && fsm_r == ST_WAIT && !slave_op && !wr_ctl |=> fsm_r == ST_WAIT;
  endproperty
  a_slave_hold: assert property (p_slave_hold) else $error("Wait state left while not slave"); // R03
  property p_ab_off;
    @(posedge clk_in) disable iff (!rst_n_in)
    ce_in && meter_done && !ab_active && !(a_wr_r && (a_sel_r == SEL_BRH || a_sel_r == SEL_BRL))
    |=> $stable(divisor_r);
  endproperty
  a_ab_off: assert property (p_ab_off) else $error("Divisor changed with autobaud off"); // R04
  property p_ab_flag;
    @(posedge clk_in) disable iff (!rst_n_in)
    ce_in && ab_hit && ab_irq_en_r && mask_r[`LIN_STAT_ABD_BIT]
    |=> stat_r[`LIN_STAT_ABD_BIT] && irq_out;
  endproperty
  a_ab_flag: assert property (p_ab_flag) else $error("Autobaud flag or interrupt missing"); // R05
  property p_ab_load;
    @(posedge clk_in) disable iff (!rst_n_in)
    ce_in && ab_hit && !wr_ctl
    |=> divisor_r == $past(meter_period) && lin_state_out == 2'b11;
  endproperty
  a_ab_load: assert property (p_ab_load) else $error("Measured period not loaded"); // R07
  property p_sw_force;
    @(posedge clk_in) disable iff (!rst_n_in)
    ce_in && wr_ctl |=> lin_state_out == $past(hwdata_in[3:2]);
  endproperty
  a_sw_force: assert property (p_sw_force) else $error("Software state write not applied"); // R08
  property p_master_stay;
    @(posedge clk_in) disable iff (!rst_n_in)
    ce_in && fsm_r == ST_ACTIVE && !wr_ctl |=> lin_state_out == 2'b11;
  endproperty
  a_master_stay: assert property (p_master_stay) else $error("Active state left by hardware"); // R11
  property p_brk_len;
    @(posedge clk_in) disable iff (!rst_n_in)
    ce_in && brk_end |=> brk_meas_r == $past(brk_total_r);
  endproperty
  a_brk_len: assert property (p_brk_len) else $error("Break length wrong"); // R13

  c_autobaud: cover property (@(posedge clk_in) disable iff (!rst_n_in) ab_hit);
  c_break:    cover property (@(posedge clk_in) disable iff (!rst_n_in) brk_end);
  c_irq:      cover property (@(posedge clk_in) disable iff (!rst_n_in) $rose(irq_out));

endmodule

/* File: lin_regs.svh */
// Register offsets, field positions, reset values and bit-time counts of the LIN mode control.
// Assumes a 32-bit AHB-Lite slave where each register holds one word at four times its index.
`ifndef LIN_REGS_SVH
`define LIN_REGS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define LIN_MODE_IDX      16'h0f40
`define LIN_CTL_IDX       16'h0f43
`define LIN_BRH_IDX       16'h0f46
`define LIN_BRL_IDX       16'h0f47
`define LIN_STAT_IDX      16'h0f48
`define LIN_MASK_IDX      16'h0f49
`define LIN_CMD_IDX       16'h0f4a

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define LIN_MODE_SEL_HI   2
`define LIN_MODE_SEL_LO   0
`define LIN_MULTIPROC_ENABLE_BIT      3
`define LIN_PEN_BIT       4
`define LIN_CTL_MST_BIT   7
`define LIN_CTL_SLV_BIT   6
`define LIN_CTL_AUTOBAUD_ENABLE_BIT_BIT  5
`define LIN_CTL_AUTOBAUD_IRQ_ENABLE_BIT 4
`define LIN_CTL_ST_HI     3
`define LIN_CTL_ST_LO     2
`define LIN_CTL_BRK_HI    1
`define LIN_CTL_BRK_LO    0
`define LIN_STAT_ABD_BIT  0
`define LIN_STAT_BRK_BIT  1
`define LIN_CMD_BRK_BIT   0

// ----------------------------------------------------------------------------
// Values, reset values and counts
// ----------------------------------------------------------------------------
`define LIN_MODE_LIN      3'b010
`define LIN_CODE_SLEEP    2'b00
`define LIN_CODE_WAIT     2'b01
`define LIN_CODE_AUTOBAUD 2'b10
`define LIN_CODE_ACTIVE   2'b11
`define LIN_MODE_RST      8'h00
`define LIN_CTL_RST       8'h00
`define LIN_BR_RST        8'hff
`define LIN_MASK_RST      8'h00
`define LIN_BREAK_BASE    5'd13
`define LIN_BREAK_DETECT  20'd11
`define LIN_SYNC_EDGES    3'd5
`define LIN_SYNC_SHIFT    3
`endif

/* File: lin_pkg.sv */
// Types shared by the LIN mode control and its helpers.
// Assumes lin_regs.svh supplies every number.
package lin_pkg;

  // --------------------------------------------------------------------------
  // State machines
  // --------------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_SLEEP    = 4'b0001,
    ST_WAIT     = 4'b0010,
    ST_AUTOBAUD = 4'b0100,
    ST_ACTIVE   = 4'b1000
  } lin_fsm_type;

  typedef enum logic [1:0] {
    BRK_IDLE = 2'b01,
    BRK_SEND = 2'b10
  } brk_fsm_type;

  // --------------------------------------------------------------------------
  // Register selection
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    SEL_NONE, SEL_MODE, SEL_CTL, SEL_BRH, SEL_BRL, SEL_STAT, SEL_MASK, SEL_CMD
  } reg_sel_type;

endpackage

/* File: lin_sync.sv */
// Two-stage synchroniser for the receive pin.
// Assumes an asynchronous pin; only the second stage may be read.
`timescale 1ns/1ps
module lin_sync (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic ce_in,
  // Pin and synchronised level
  input  wire logic pin_in,
  output logic      sync_out
);

  logic meta_r;

  // The line idles high, so both stages reset to one.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_r   <= 1'b1;
      sync_out <= 1'b1;
    end else if (ce_in) begin
      meta_r   <= pin_in;
      sync_out <= meta_r;
    end
  end

endmodule

/* File: lin_autobaud_meter.sv */
// Measures the bit period from the sync character after a break.
// Assumes a synchronised receive level and an arm level held through the measurement.
`timescale 1ns/1ps
`include "lin_regs.svh"
module lin_autobaud_meter #(
  parameter int CNT_W = 19
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        ce_in,
  // Control and line
  input  wire logic        arm_in,
  input  wire logic        rx_in,
  // Result
  output logic             done_out,
  output logic [15:0]      period_out
);

  logic             rx_d_r;
  logic [2:0]       edges_r;
  logic [CNT_W-1:0] cnt_r;
  logic             fall;

  assign fall = rx_d_r & ~rx_in;

  // Five falling edges of the sync character span eight bit times.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_d_r     <= 1'b1;
      edges_r    <= 3'd0;
      cnt_r      <= '0;
      done_out   <= 1'b0;
      period_out <= 16'h0000;
    end else if (ce_in) begin
      rx_d_r   <= rx_in;
      done_out <= 1'b0;
      if (!arm_in) begin
        edges_r <= 3'd0;
        cnt_r   <= '0;
      end else if (edges_r != `LIN_SYNC_EDGES) begin
        if (edges_r != 3'd0) begin
          cnt_r <= cnt_r + 1'b1;
        end
        if (fall) begin
          edges_r <= edges_r + 3'd1;
          if (edges_r == `LIN_SYNC_EDGES - 3'd1) begin
            done_out   <= 1'b1;
            period_out <= 16'((cnt_r + CNT_W'(5)) >> `LIN_SYNC_SHIFT);
          end
        end
      end
    end
  end

endmodule

/* File: lin_node_model.sv */
// Behavioural LIN node that sends a break and then a sync character on request.
// Assumes go_in pulses high for one cycle; the line idles high between frames.
`timescale 1ns/1ps
module lin_node_model #(
  parameter int BIT_CYC = 16
) (
  // Clock and request
  input  wire logic clk_in,
  input  wire logic go_in,
  // Line
  output logic      rx_out
);
  logic [9:0] frame;
  initial rx_out = 1'b1;
  always begin
    @(posedge go_in);
    frame = {1'b1, 8'h55, 1'b0};
    rx_out <= 1'b0;
    repeat (13 * BIT_CYC) @(posedge clk_in);
    rx_out <= 1'b1;
    repeat (BIT_CYC) @(posedge clk_in);
    for (int i = 0; i < 10; i++) begin
      rx_out <= frame[i];
      repeat (BIT_CYC) @(posedge clk_in);
    end
  end
endmodule

/* File: lin_mode_control_bench.sv */
// Self-checking bench for the LIN mode control.
// Assumes the LIN node model drives the receive pin.
`timescale 1ns/1ps
`include "lin_regs.svh"
module lin_mode_control_bench;
  import lin_pkg::*;
  `define CHK(n, e, v) begin cmp_count++; if ((v) !== (e)) begin n_mismatch++; \
    $display("mismatch %s exp %h got %h", n, e, v); end end
  logic        clk_in, rst_n_in, hw, rdy, resp, txb, irq, rx, go, ce;
  logic [1:0]  ht, st;
  logic [31:0] ha, hwd, hrd, q;
  int          n_mismatch, cmp_count, n;
  lin_mode_control lin_mode_control_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .ce_in(ce), .hsel_in(1'b1), .haddr_in(ha), .htrans_in(ht), .hwrite_in(hw),
    .hsize_in(3'b010), .hwdata_in(hwd), .hready_in(rdy), .hrdata_out(hrd),
    .hreadyout_out(rdy), .hresp_out(resp), .rx_pin_in(rx), .tx_break_out(txb),
    .lin_state_out(st), .irq_out(irq));
  lin_node_model #(.BIT_CYC(16)) lin_node_model_i (.clk_in(clk_in), .go_in(go),
    .rx_out(rx));
  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  function logic [31:0] ad(input logic [15:0] i);
    return {14'h0, i, 2'b00};
  endfunction
  task xfer(input logic [31:0] a, input logic w, input logic [7:0] d);
    ha <= a; ht <= 2'b10; hw <= w;
    do @(posedge clk_in); while (rdy !== 1'b1);
    ht <= 2'b00; hwd <= {24'h0, d};
    do @(posedge clk_in); while (rdy !== 1'b1);
    q = hrd;
  endtask
  task rd(input logic [15:0] i, input logic [31:0] e, input string s);
    xfer(ad(i), 1'b0, 8'h00);
    `CHK(s, e, q)
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset;
    rd(`LIN_BRH_IDX, 32'h0000_00ff, "brh");
    rd(`LIN_BRL_IDX, 32'h0000_00ff, "brl");
    rd(16'h0f4f, 32'h0, "unmapped");
    `CHK("resp", 1'b0, resp)
  endtask
  task t_hidden;
    xfer(ad(`LIN_CTL_IDX), 1'b1, 8'h8c);
    xfer(ad(`LIN_MODE_IDX), 1'b1, {5'h0, `LIN_MODE_LIN});
    rd(`LIN_CTL_IDX, 32'h0, "ctl hidden");
    `CHK("state", 2'b00, st)
  endtask
  task t_master;
    xfer(ad(`LIN_CTL_IDX), 1'b1, 8'h8c);
    @(posedge clk_in);
    `CHK("state", 2'b11, st)
    rd(`LIN_CTL_IDX, 32'h8c, "ctl");
    ce <= 1'b0;
    xfer(ad(`LIN_CTL_IDX), 1'b1, 8'h80);
    ce <= 1'b1;
    @(posedge clk_in);
    `CHK("frozen", 2'b11, st)
    xfer(ad(`LIN_CTL_IDX), 1'b1, 8'h88);
    repeat (20) @(posedge clk_in);
    `CHK("state", 2'b10, st)
    xfer(ad(`LIN_CTL_IDX), 1'b1, 8'h8c);
    repeat (20) @(posedge clk_in);
    `CHK("state", 2'b11, st)
  endtask
  task t_break;
    xfer(ad(`LIN_BRH_IDX), 1'b1, 8'h00);
    xfer(ad(`LIN_BRL_IDX), 1'b1, 8'h02);
    for (int l = 0; l < 4; l++) begin
      xfer(ad(`LIN_CTL_IDX), 1'b1, 8'h8c | 8'(l));
      xfer(ad(`LIN_CMD_IDX), 1'b1, 8'h01);
      #1;
      n = 0;
      while (txb === 1'b0 && n < 100) begin
        @(posedge clk_in);
        #1;
        n++;
      end
      `CHK("break len", 32'((13 + l) * 2), 32'(n))
      @(posedge clk_in);
    end
    `CHK("irq masked", 1'b0, irq)
    rd(`LIN_STAT_IDX, 32'h2, "stat brk");
  endtask
  task t_slave;
    xfer(ad(`LIN_BRL_IDX), 1'b1, 8'h04);
    xfer(ad(`LIN_MASK_IDX), 1'b1, 8'h01);
    xfer(ad(`LIN_CTL_IDX), 1'b1, 8'h74);
    @(posedge clk_in);
    `CHK("state", 2'b01, st)
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    n = 0;
    while (st !== 2'b11 && n < 2000) begin
      @(posedge clk_in);
      n++;
    end
    `CHK("state", 2'b11, st)
    repeat (3) @(posedge clk_in);
    `CHK("irq", 1'b1, irq)
    rd(`LIN_STAT_IDX, 32'h1, "stat");
    rd(`LIN_BRH_IDX, 32'h0, "brh");
    rd(`LIN_BRL_IDX, 32'h10, "brl");
    repeat (2) @(posedge clk_in);
    `CHK("irq clr", 1'b0, irq)
    xfer(ad(`LIN_CTL_IDX), 1'b1, 8'h70);
    @(posedge clk_in);
    `CHK("state", 2'b00, st)
    xfer(ad(`LIN_MODE_IDX), 1'b1, 8'h00);
    rd(`LIN_CTL_IDX, 32'h0, "ctl off");
  endtask
  // ----------------------------------------------------------------
  // Sequence and verdict
  // ----------------------------------------------------------------
  task stop_test;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  // A hang in a wait loop would otherwise run forever.
  initial begin
    repeat (50000) @(posedge clk_in);
    n_mismatch++;
    stop_test;
  end
  initial begin
    n_mismatch = 0; cmp_count = 0; rst_n_in = 1'b0;
    ha = 32'h0; ht = 2'b00; hw = 1'b0; hwd = 32'h0; go = 1'b0;
    ce = 1'b1;
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    t_reset;
    t_hidden;
    t_master;
    t_break;
    t_slave;
    stop_test;
  end
endmodule
